// ### hdl/fcr_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Underflow sets bit 6, overflow sets bit 5 of last-byte status.
// - Incomplete final received byte sets bit 4.
// - Valid-bit count in bits 3..1; received bits packed into byte LSBs.
// - Missing parity on final byte sets bit 0, a framing error.
// - Empty FIFO keeps incomplete flag and bit count cleared.
// - Reading last-byte status clears incomplete flag, count and parity flag.
// - Collision stores complete byte count in bits 7..4.
// - Collision stores bit position within byte in bits 3..1.
// - Bit 0 marks parity-bit collision, only for the first collision.
// - Collisions beyond anticollision command range leave the register unchanged.
// - Transmit length is 13 bits: high 8 bits, then low 5 in bits 7..3.
// - Bits 2..0 give split byte bit count; zero means no split byte.
// - Anticollision frame with split byte is sent without parity bits.
// - Status and collision registers reset to zero at power-up and set-default.
// - Both transmit length registers load zero at power-up and set-default.
module fcr_regs
    import fcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic set_default,
    input wire fcr_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic fifo_underflow,
    input wire logic fifo_overflow,
    input wire logic fifo_empty,
    input wire fcr_rx_last_t rx_last,
    input wire logic rx_start,
    input wire fcr_col_evt_t col_evt,
    input wire logic anticol_mode,
    output logic [7:0] fifo_wr_data,
    output logic fifo_wr_valid,
    output logic [12:0] tx_length,
    output logic [2:0] tx_split_bits,
    output logic tx_parity_en
);

    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] coll_reg;
    logic [7:0] coll_next;
    logic [7:0] tx_high_reg;
    logic [7:0] tx_high_next;
    logic [7:0] tx_low_reg;
    logic [7:0] tx_low_next;
    logic col_seen_reg;
    logic col_seen_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] wr_data_reg;
    logic [7:0] wr_data_next;
    logic wr_valid_reg;
    logic parity_en_reg;
    logic parity_en_next;

    wire rd_status = bus_req.rd && bus_req.addr == FCR_ADDR_FIFO_LAST_BYTE_STATUS;
    wire wr_high = bus_req.wr && bus_req.addr == FCR_ADDR_TX_LENGTH_HIGH;
    wire wr_low = bus_req.wr && bus_req.addr == FCR_ADDR_TX_LENGTH_LOW_SPLIT;
    wire last_partial = rx_last.valid && !rx_last.complete;
    wire col_take = col_evt.hit && col_evt.in_range && !col_seen_reg;
    wire [7:0] keep_mask = rx_last.complete ? 8'hff : 8'hff >> (4'h8 - {1'b0, rx_last.nbits});

    // Underflow and overflow are sticky; a new event wins over the read clear
    wire unf_next = fifo_underflow || (status_reg[FCR_UNF_BIT] && !rd_status);
    wire ovr_next = fifo_overflow || (status_reg[FCR_OVR_BIT] && !rd_status);
    // Last-byte info: new byte wins over the read clear, empty FIFO wins over both for the incomplete flag and count
    wire ncp_next = !fifo_empty && (last_partial
        || (status_reg[FCR_NCP_BIT] && !rd_status && !rx_last.valid));
    wire [2:0] lb_next = fifo_empty ? 3'h0 : last_partial ? rx_last.nbits
        : (rx_last.valid || rd_status) ? 3'h0
        : status_reg[FCR_LB_MSB:FCR_LB_LSB];
    wire np_next = rx_last.valid ? rx_last.no_parity
        : (status_reg[FCR_NP_BIT] && !rd_status);

    assign status_next = {1'b0, unf_next, ovr_next, ncp_next, lb_next, np_next};

    // First in-range collision of a frame is captured, later ones are ignored
    assign coll_next = col_take ? {col_evt.bytes, col_evt.bits, col_evt.on_parity}
        : coll_reg;
    assign col_seen_next = col_take || (col_seen_reg && !rx_start);

    assign tx_high_next = wr_high ? bus_req.wdata : tx_high_reg;
    assign tx_low_next = wr_low ? bus_req.wdata : tx_low_reg;

    assign rdata_next = !bus_req.rd ? rdata_reg
        : bus_req.addr == FCR_ADDR_FIFO_LAST_BYTE_STATUS ? status_reg
        : bus_req.addr == FCR_ADDR_COLLISION_POSITION ? coll_reg
        : bus_req.addr == FCR_ADDR_TX_LENGTH_HIGH ? tx_high_reg
        : bus_req.addr == FCR_ADDR_TX_LENGTH_LOW_SPLIT ? tx_low_reg
        : FCR_UNMAPPED_READ;

    // Partial byte keeps only its received bits, in the low positions
    assign wr_data_next = rx_last.valid ? (rx_last.data & keep_mask) : wr_data_reg;

    // Split-byte anticollision frames go out without parity
    assign parity_en_next = !(anticol_mode
        && tx_low_next[FCR_NBTX_MSB:FCR_NBTX_LSB] != FCR_NO_SPLIT);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= FCR_RST_FIFO_LAST_BYTE_STATUS;
            coll_reg <= FCR_RST_COLLISION_POSITION;
            col_seen_reg <= 1'b0;
            tx_high_reg <= FCR_RST_TX_LENGTH_HIGH;
            tx_low_reg <= FCR_RST_TX_LENGTH_LOW_SPLIT;
        end else if (clk_en && set_default) begin
            status_reg <= FCR_RST_FIFO_LAST_BYTE_STATUS;
            coll_reg <= FCR_RST_COLLISION_POSITION;
            col_seen_reg <= 1'b0;
            tx_high_reg <= FCR_RST_TX_LENGTH_HIGH;
            tx_low_reg <= FCR_RST_TX_LENGTH_LOW_SPLIT;
        end else if (clk_en) begin
            status_reg <= status_next;
            coll_reg <= coll_next;
            col_seen_reg <= col_seen_next;
            tx_high_reg <= tx_high_next;
            tx_low_reg <= tx_low_next;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= FCR_UNMAPPED_READ;
            wr_data_reg <= 8'h00;
            wr_valid_reg <= 1'b0;
            parity_en_reg <= 1'b1;
        end else if (clk_en) begin
            rdata_reg <= rdata_next;
            wr_data_reg <= wr_data_next;
            wr_valid_reg <= rx_last.valid;
            parity_en_reg <= set_default ? 1'b1 : parity_en_next;
        end
    end

    assign bus_rdata = rdata_reg;
    assign fifo_wr_data = wr_data_reg;
    assign fifo_wr_valid = wr_valid_reg;
    assign tx_length = {tx_high_reg, tx_low_reg[FCR_NTX_LOW_MSB:FCR_NTX_LOW_LSB]};
    assign tx_split_bits = tx_low_reg[FCR_NBTX_MSB:FCR_NBTX_LSB];
    assign tx_parity_en = parity_en_reg;

    property p_unf_set;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && fifo_underflow |=> status_reg[FCR_UNF_BIT];
    endproperty
    a_unf_set: assert property (p_unf_set) else $error("underflow flag not set");

    property p_ovr_set;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && fifo_overflow |=> status_reg[FCR_OVR_BIT];
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overflow flag not set");

    property p_partial_count;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && !fifo_empty && last_partial
        |=> status_reg[FCR_NCP_BIT] && status_reg[FCR_LB_MSB:FCR_LB_LSB] == $past(rx_last.nbits);
    endproperty
    a_partial_count: assert property (p_partial_count) else $error("partial byte not reported");

    property p_pack_low;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && rx_last.valid && !rx_last.complete
        |=> fifo_wr_valid && ((fifo_wr_data >> $past(rx_last.nbits)) == 8'h00);
    endproperty
    a_pack_low: assert property (p_pack_low) else $error("partial byte not packed low");

    property p_np_set;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && rx_last.valid && rx_last.no_parity |=> status_reg[FCR_NP_BIT];
    endproperty
    a_np_set: assert property (p_np_set) else $error("missing parity not flagged");

    property p_empty_clear;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && fifo_empty |=> status_reg[FCR_NCP_BIT:FCR_LB_LSB] == 4'h0;
    endproperty
    a_empty_clear: assert property (p_empty_clear) else $error("empty fifo left last-byte info");

    property p_read_clear;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && rd_status && !rx_last.valid
        |=> status_reg[FCR_NCP_BIT:FCR_NP_BIT] == 5'h00 && bus_rdata == $past(status_reg);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

    property p_coll_capture;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && col_take
        |=> coll_reg == {$past(col_evt.bytes), $past(col_evt.bits), $past(col_evt.on_parity)};
    endproperty
    a_coll_capture: assert property (p_coll_capture) else $error("collision not captured");

    property p_coll_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && col_evt.hit && (!col_evt.in_range || col_seen_reg)
        |=> $stable(coll_reg);
    endproperty
    a_coll_hold: assert property (p_coll_hold) else $error("collision register changed");

    property p_default_zero;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && set_default
        |=> status_reg == 8'h00 && coll_reg == 8'h00 && tx_length == 13'h0000 && tx_split_bits == 3'h0;
    endproperty
    a_default_zero: assert property (p_default_zero) else $error("set-default left a value");

    property p_no_parity;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && anticol_mode && tx_split_bits != FCR_NO_SPLIT
        && !(bus_req.wr && bus_req.addr == FCR_ADDR_TX_LENGTH_LOW_SPLIT)
        |=> !tx_parity_en;
    endproperty
    a_no_parity: assert property (p_no_parity) else $error("parity kept on split frame");

    property p_parity_on;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && (set_default || !anticol_mode)
        |=> tx_parity_en;
    endproperty
    a_parity_on: assert property (p_parity_on) else $error("parity dropped");

    property p_unf_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && !fifo_underflow && !rd_status
        |=> $stable(status_reg[FCR_UNF_BIT]);
    endproperty
    a_unf_hold: assert property (p_unf_hold) else $error("underflow flag moved");

    property p_ovr_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && !fifo_overflow && !rd_status
        |=> $stable(status_reg[FCR_OVR_BIT]);
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("overflow flag moved");

    property p_complete_clear;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && rx_last.valid && rx_last.complete
        |=> status_reg[FCR_NCP_BIT:FCR_LB_LSB] == 4'h0;
    endproperty
    a_complete_clear: assert property (p_complete_clear) else $error("complete byte flagged");

    property p_np_follow;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && rx_last.valid
        |=> status_reg[FCR_NP_BIT] == $past(rx_last.no_parity);
    endproperty
    a_np_follow: assert property (p_np_follow) else $error("parity flag wrong");

    property p_pack_keep;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && rx_last.valid && !rx_last.complete
        |=> ((fifo_wr_data ^ $past(rx_last.data)) & ~(8'hff << $past(rx_last.nbits))) == 8'h00;
    endproperty
    a_pack_keep: assert property (p_pack_keep) else $error("received bits lost");

    property p_complete_pass;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && rx_last.valid && rx_last.complete
        |=> fifo_wr_data == $past(rx_last.data);
    endproperty
    a_complete_pass: assert property (p_complete_pass) else $error("complete byte altered");

    property p_coll_bits;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && col_evt.hit && col_evt.in_range && !col_seen_reg
        |=> coll_reg[FCR_CBIT_MSB:FCR_CBIT_LSB] == $past(col_evt.bits);
    endproperty
    a_coll_bits: assert property (p_coll_bits) else $error("collision bit wrong");

    property p_coll_parity_first;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && col_evt.hit && col_seen_reg && !coll_reg[FCR_CPB_BIT]
        |=> !coll_reg[FCR_CPB_BIT];
    endproperty
    a_coll_parity_first: assert property (p_coll_parity_first) else $error("late parity hit");

    property p_coll_read;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && bus_req.rd && bus_req.addr == FCR_ADDR_COLLISION_POSITION
        |=> bus_rdata == $past(coll_reg);
    endproperty
    a_coll_read: assert property (p_coll_read) else $error("collision read wrong");

    property p_tx_high_write;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && bus_req.wr && bus_req.addr == FCR_ADDR_TX_LENGTH_HIGH
        |=> tx_length == {$past(bus_req.wdata), $past(tx_length[4:0])};
    endproperty
    a_tx_high_write: assert property (p_tx_high_write) else $error("high length lost");

    property p_tx_low_write;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && bus_req.wr && bus_req.addr == FCR_ADDR_TX_LENGTH_LOW_SPLIT
        |=> {tx_length[4:0], tx_split_bits} == $past(bus_req.wdata);
    endproperty
    a_tx_low_write: assert property (p_tx_low_write) else $error("low length lost");

    property p_tx_stable;
        @(posedge sys_clk) disable iff (!arst_n)
        clk_en && !set_default && !bus_req.wr
        |=> $stable(tx_length) && $stable(tx_split_bits);
    endproperty
    a_tx_stable: assert property (p_tx_stable) else $error("length moved");

endmodule // fcr_regs

// ### hdl/fcr_pkg.sv
package fcr_pkg;

    // Register addresses
    localparam logic [7:0] FCR_ADDR_FIFO_LAST_BYTE_STATUS = 8'h1b;
    localparam logic [7:0] FCR_ADDR_COLLISION_POSITION = 8'h1c;
    localparam logic [7:0] FCR_ADDR_TX_LENGTH_HIGH = 8'h1d;
    localparam logic [7:0] FCR_ADDR_TX_LENGTH_LOW_SPLIT = 8'h1e;

    // Values after reset and set-default; value read at unmapped addresses
    localparam logic [7:0] FCR_RST_FIFO_LAST_BYTE_STATUS = 8'h00;
    localparam logic [7:0] FCR_RST_COLLISION_POSITION = 8'h00;
    localparam logic [7:0] FCR_RST_TX_LENGTH_HIGH = 8'h00;
    localparam logic [7:0] FCR_RST_TX_LENGTH_LOW_SPLIT = 8'h00;
    localparam logic [7:0] FCR_UNMAPPED_READ = 8'h00;

    // Last-byte status field positions
    localparam int FCR_UNF_BIT = 6;
    localparam int FCR_OVR_BIT = 5;
    localparam int FCR_NCP_BIT = 4;
    localparam int FCR_LB_MSB = 3;
    localparam int FCR_LB_LSB = 1;
    localparam int FCR_NP_BIT = 0;

    // Collision position field positions
    localparam int FCR_CBYTE_MSB = 7;
    localparam int FCR_CBYTE_LSB = 4;
    localparam int FCR_CBIT_MSB = 3;
    localparam int FCR_CBIT_LSB = 1;
    localparam int FCR_CPB_BIT = 0;

    // Transmit length layout
    localparam int FCR_NTX_LOW_MSB = 7;
    localparam int FCR_NTX_LOW_LSB = 3;
    localparam int FCR_NBTX_MSB = 2;
    localparam int FCR_NBTX_LSB = 0;
    localparam logic [12:0] FCR_TX_LEN_MAX = 13'h1fff;
    localparam logic [2:0] FCR_NO_SPLIT = 3'h0;

    // Register access from the serial port engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fcr_bus_req_t;

    // Last received byte as it enters the FIFO
    typedef struct packed {
        logic valid;
        logic complete;
        logic [2:0] nbits;
        logic no_parity;
        logic [7:0] data;
    } fcr_rx_last_t;

    // Bit collision report from the framing logic
    typedef struct packed {
        logic hit;
        logic in_range;
        logic [3:0] bytes;
        logic [2:0] bits;
        logic on_parity;
    } fcr_col_evt_t;

endpackage

// ### test/fcr_host_model.sv
`timescale 1ns/1ps
module fcr_host_model
    import fcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [7:0] bus_rdata,
    output fcr_bus_req_t bus_req
);
    logic [7:0] status_copy;
    initial begin
        bus_req = '0;
        status_copy = 8'h00;
    end
    // One strobe cycle; address and data flip once released
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge sys_clk);
        bus_req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge sys_clk);
        bus_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        @(posedge sys_clk);
        #1 q = bus_rdata;
    endtask
    // Both status registers before FIFO data, the second one kept
    task automatic read_status(output logic [7:0] q);
        logic [7:0] cnt;
        access(1'b0, 8'h1a, 8'h00, cnt);
        access(1'b0, FCR_ADDR_FIFO_LAST_BYTE_STATUS, 8'h00, status_copy);
        q = status_copy;
    endtask
endmodule // fcr_host_model

// ### test/test_fcr_regs.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_fcr_regs
    import fcr_pkg::*;
;
    logic sys_clk, arst_n, clk_en, set_default, fifo_underflow, fifo_overflow, fifo_empty;
    logic rx_start, anticol_mode, fifo_wr_valid, tx_parity_en;
    logic [7:0] bus_rdata, fifo_wr_data, q;
    logic [12:0] tx_length;
    logic [2:0] tx_split_bits;
    fcr_bus_req_t bus_req;
    fcr_rx_last_t rx_last;
    fcr_col_evt_t col_evt;
    int miscompares = 0;
    int num_checks = 0;

    fcr_regs DUT (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .set_default(set_default), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .fifo_underflow(fifo_underflow), .fifo_overflow(fifo_overflow),
        .fifo_empty(fifo_empty), .rx_last(rx_last), .rx_start(rx_start),
        .col_evt(col_evt), .anticol_mode(anticol_mode), .fifo_wr_data(fifo_wr_data),
        .fifo_wr_valid(fifo_wr_valid), .tx_length(tx_length),
        .tx_split_bits(tx_split_bits), .tx_parity_en(tx_parity_en));
    fcr_host_model host (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_req(bus_req));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic conclude;
        $display("Checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
        host.access(1'b0, a, 8'h00, q);
        `CHK(n, e, q)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q);
    endtask
    // Ends every event pulse one cycle after it was raised
    task automatic fire;
        @(posedge sys_clk);
        {fifo_underflow, fifo_overflow, rx_start, set_default} <= 4'h0;
        rx_last.valid <= 1'b0;
        col_evt.hit <= 1'b0;
    endtask

    initial begin
        repeat (4000) @(posedge sys_clk);
        miscompares++;
        conclude();
    end

    initial begin
        {arst_n, set_default, fifo_underflow, fifo_overflow, fifo_empty, rx_start} = '0;
        clk_en = 1'b1;
        anticol_mode = 1'b1;
        rx_last = '0;
        col_evt = '0;
        repeat (20) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk(FCR_ADDR_FIFO_LAST_BYTE_STATUS, 8'h00, "status rst");
        rd_chk(FCR_ADDR_COLLISION_POSITION, 8'h00, "collision rst");
        rd_chk(FCR_ADDR_TX_LENGTH_HIGH, 8'h00, "tx high rst");
        rd_chk(FCR_ADDR_TX_LENGTH_LOW_SPLIT, 8'h00, "tx low rst");
        rd_chk(8'h1f, 8'h00, "unmapped");
        wr(FCR_ADDR_TX_LENGTH_HIGH, 8'hff);
        wr(FCR_ADDR_TX_LENGTH_LOW_SPLIT, 8'hfd);
        `CHK("tx length", FCR_TX_LEN_MAX, tx_length)
        `CHK("split bits", 3'h5, tx_split_bits)
        `CHK("parity off", 1'b0, tx_parity_en)
        rd_chk(FCR_ADDR_TX_LENGTH_LOW_SPLIT, 8'hfd, "tx low");
        @(posedge sys_clk) anticol_mode <= 1'b0;
        @(posedge sys_clk);
        #1 `CHK("parity plain", 1'b1, tx_parity_en)
        anticol_mode <= 1'b1;
        wr(FCR_ADDR_TX_LENGTH_LOW_SPLIT, 8'hf8);
        `CHK("no split", FCR_NO_SPLIT, tx_split_bits)
        `CHK("parity on", 1'b1, tx_parity_en)
        @(posedge sys_clk) fifo_underflow <= 1'b1;
        fire();
        @(posedge sys_clk) fifo_overflow <= 1'b1;
        fire();
        rd_chk(FCR_ADDR_FIFO_LAST_BYTE_STATUS, 8'h60, "unf ovr");
        @(posedge sys_clk) rx_last <= '{1'b1, 1'b0, 3'h3, 1'b1, 8'hff};
        fire();
        #1 `CHK("wr valid", 1'b1, fifo_wr_valid)
        `CHK("wr data", 8'h07, fifo_wr_data)
        host.read_status(q);
        `CHK("last byte", 8'h17, q)
        rd_chk(FCR_ADDR_FIFO_LAST_BYTE_STATUS, 8'h00, "read clear");
        @(posedge sys_clk) clk_en <= 1'b0;
        fifo_underflow <= 1'b1;
        fire();
        clk_en <= 1'b1;
        rd_chk(FCR_ADDR_FIFO_LAST_BYTE_STATUS, 8'h00, "frozen");
        @(posedge sys_clk) fifo_empty <= 1'b1;
        rx_last <= '{1'b1, 1'b0, 3'h5, 1'b0, 8'h1f};
        fire();
        rd_chk(FCR_ADDR_FIFO_LAST_BYTE_STATUS, 8'h00, "empty");
        @(posedge sys_clk) fifo_empty <= 1'b0;
        rx_start <= 1'b1;
        fire();
        @(posedge sys_clk) col_evt <= '{1'b1, 1'b1, 4'h5, 3'h3, 1'b1};
        fire();
        @(posedge sys_clk) col_evt <= '{1'b1, 1'b1, 4'h2, 3'h1, 1'b0};
        fire();
        rd_chk(FCR_ADDR_COLLISION_POSITION, 8'h57, "first col");
        @(posedge sys_clk) rx_start <= 1'b1;
        fire();
        @(posedge sys_clk) col_evt <= '{1'b1, 1'b0, 4'h9, 3'h6, 1'b0};
        fire();
        rd_chk(FCR_ADDR_COLLISION_POSITION, 8'h57, "out of range");
        @(posedge sys_clk) col_evt <= '{1'b1, 1'b1, 4'h2, 3'h1, 1'b0};
        fire();
        rd_chk(FCR_ADDR_COLLISION_POSITION, 8'h22, "second frame");
        @(posedge sys_clk) fifo_underflow <= 1'b1;
        fire();
        @(posedge sys_clk) set_default <= 1'b1;
        fire();
        rd_chk(FCR_ADDR_FIFO_LAST_BYTE_STATUS, 8'h00, "status dflt");
        rd_chk(FCR_ADDR_COLLISION_POSITION, 8'h00, "collision dflt");
        rd_chk(FCR_ADDR_TX_LENGTH_HIGH, 8'h00, "tx high dflt");
        `CHK("tx length dflt", 13'h0000, tx_length)
        wr(FCR_ADDR_TX_LENGTH_LOW_SPLIT, 8'h2b);
        `CHK("parity split", 1'b0, tx_parity_en)
        @(posedge sys_clk) arst_n <= 1'b0;
        @(posedge sys_clk) arst_n <= 1'b1;
        #1 `CHK("parity rst", 1'b1, tx_parity_en)
        rd_chk(FCR_ADDR_TX_LENGTH_LOW_SPLIT, 8'h00, "tx low rst2");
        conclude();
    end
endmodule // test_fcr_regs
